/* hdl/seg_context_defines.svh */
// Function
// RULE_01: abr suspend flag halts transmission; resets zero
// RULE_02: two-bit drop select picks one of four
// RULE_03: fetch starts at buffer offset in buffer
// RULE_04: enable bit ors modifier into event bits 8-7
// RULE_05: modifier only for buffer-address events
// RULE_06: entry point loaded into both instruction pointers
// RULE_07: entry point selects generated cell type
// RULE_08: first four header bytes from stored header
// RULE_09: segmentation pointer set when frame queued
// RULE_10: running crc kept and updated per word
// RULE_11: eight-bit count of words sent
// RULE_12: software sets words per packet block size
// RULE_13: eight-bit current transport packet index
// RULE_14: packets per frame concatenated into aal5 frame
// RULE_15: counters only initialised by software, then hardware; code has no software write, zeroes them on the start write
// RULE_16: sixteen-bit explicit rate register for abr
// RULE_17: block count wraps, advancing packet index
// RULE_18: index reaching packets per frame closes frame
`ifndef SEG_CONTEXT_DEFINES_SVH
`define SEG_CONTEXT_DEFINES_SVH

`define SEG_REG_CTRL       6'h00
`define SEG_REG_OFFSET     6'h01
`define SEG_REG_ENTRY      6'h02
`define SEG_REG_HEADER     6'h03
`define SEG_REG_POINTER    6'h04
`define SEG_REG_CRC        6'h05
`define SEG_REG_BLOCK      6'h06
`define SEG_REG_RATE       6'h07
`define SEG_REG_IRQ_STAT   6'h08
`define SEG_REG_IRQ_CLR    6'h09
`define SEG_REG_IRQ_EN     6'h0A
`define SEG_REG_EVENT      6'h0B

`define SEG_CTRL_SUSPEND   0
`define SEG_CTRL_DROP_LO   1
`define SEG_CTRL_DROP_HI   2
`define SEG_CTRL_ABR       3
`define SEG_CTRL_MOD_EN    4
`define SEG_CTRL_ADDR_EVT  5
`define SEG_CTRL_START     6

`define SEG_EVT_MOD_LO     7
`define SEG_EVT_MOD_HI     8

`define SEG_IRQ_CELL       0
`define SEG_IRQ_FRAME      1
`define SEG_IRQ_PACKET     2
`define SEG_IRQ_BITS       3

`define SEG_CRC_POLY       32'h04C1_1DB7
`define SEG_CRC_INIT       32'hFFFF_FFFF
`define SEG_WORD_BYTES     32'h0000_0004
`define SEG_CELL_WORDS     4'hC
`define SEG_ZERO32         32'h0000_0000

`endif

/* hdl/seg_context_pkg.sv */
package seg_context_pkg;

	typedef enum logic [1:0]
	{
		ST_IDLE    = 2'b00,
		ST_HEADER  = 2'b01,
		ST_PAYLOAD = 2'b10,
		ST_TRAILER = 2'b11
	} seg_state_e;

endpackage

/* hdl/seg_crc_word.sv */
`timescale 1ns/1ps
`default_nettype none
`include "seg_context_defines.svh"

module seg_crc_word
(
	input  wire logic [31:0] i_crc,
	input  wire logic [31:0] i_data,
	output logic      [31:0] o_crc
);

	// msb-first serial crc unrolled over one word
	function automatic logic [31:0] crc_step(input logic [31:0] crc, input logic [31:0] data);
		logic [31:0] c;
		c = crc;
		for (int i = 31; i >= 0; i--)
		begin
			if (c[31] ^ data[i])
				c = {c[30:0], 1'b0} ^ `SEG_CRC_POLY;
			else
				c = {c[30:0], 1'b0};
		end
		return c;
	endfunction

	always_comb
	begin
		o_crc = crc_step(i_crc, i_data);
	end

endmodule
`default_nettype wire

/* hdl/atm_segmentation_context.sv */
// Our own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "seg_context_defines.svh"

module atm_segmentation_context
#(
	parameter int CNT_W = 8,
	parameter int OFS_W = 16
)
(
	input  wire logic             i_mclk,
	input  wire logic             i_reset_n,
	input  wire logic             i_hsel,
	input  wire logic [31:0]      i_haddr,
	input  wire logic [1:0]       i_htrans,
	input  wire logic             i_hwrite,
	input  wire logic [2:0]       i_hsize,
	input  wire logic [31:0]      i_hwdata,
	input  wire logic             i_hready,
	output logic      [31:0]      o_hrdata,
	output logic                  o_hreadyout,
	output logic                  o_hresp,
	input  wire logic             i_cell_opportunity,
	input  wire logic [31:0]      i_descriptor_addr,
	output logic                  o_fetch_req,
	output logic      [31:0]      o_fetch_addr,
	input  wire logic             i_fetch_valid,
	input  wire logic [31:0]      i_fetch_data,
	output logic                  o_cell_start,
	output logic      [31:0]      o_cell_header,
	output logic      [3:0]       o_update_ip,
	output logic      [3:0]       o_cellgen_ip,
	output logic      [3:0]       o_drop,
	output logic                  o_word_valid,
	output logic      [31:0]      o_word_data,
	output logic                  o_word_last,
	output logic                  o_tx_event_valid,
	output logic      [31:0]      o_tx_event,
	output logic                  o_irq
);

	// software-written context
	logic                         conn_suspend;
	logic [1:0]                   drop_select;
	logic                         abr_mode;
	logic                         segmentation_buffer_control;
	logic                         address_events;
	logic [OFS_W-1:0]             buffer_offset;
	logic [1:0]                   event_modifier;
	logic [3:0]                   entry_point;
	logic [31:0]                  cell_header_bytes;
	logic [31:0]                  buffer_base;
	logic [CNT_W-1:0]             fixed_block_size;
	logic [CNT_W-1:0]             packets_per_frame;
	logic [15:0]                  explicit_rate;
	logic [`SEG_IRQ_BITS-1:0]     irq_enable;

	// hardware-owned context
	seg_context_pkg::seg_state_e  state;
	logic [31:0]                  seg_pointer;
	logic [31:0]                  current_crc;
	logic [31:0]                  next_crc;
	logic [CNT_W-1:0]             block_count;
	logic [CNT_W-1:0]             packet_index;
	logic [3:0]                   word_count;
	logic                         frame_active;
	logic                         frame_end;
	logic [`SEG_IRQ_BITS-1:0]     irq_status;
	logic [`SEG_IRQ_BITS-1:0]     irq_set;

	// bus slave
	logic                         wr_pending;
	logic [5:0]                   wr_index;
	logic                         bus_req;
	logic                         wr_now;
	logic                         start_req;

	// word-step decodes
	logic                         word_take;
	logic                         block_hit;
	logic                         packet_hit;
	logic                         cell_done;

	function automatic logic reg_hit(input logic [5:0] idx, input logic [5:0] target);
		return idx == target;
	endfunction

	assign bus_req     = i_hsel & i_htrans[1] & i_hready;
	assign wr_now      = wr_pending;
	assign o_hreadyout = 1'b1;
	assign o_hresp     = 1'b0;
	// a start while a frame is still running is ignored, not queued
	assign start_req   = wr_now & reg_hit(wr_index, `SEG_REG_CTRL) & i_hwdata[`SEG_CTRL_START] & ~frame_active;

	assign word_take   = (state == seg_context_pkg::ST_PAYLOAD) & i_fetch_valid;
	assign block_hit   = (block_count + CNT_W'(1)) == fixed_block_size; // RULE_12
	assign packet_hit  = (packet_index + CNT_W'(1)) == packets_per_frame;
	assign cell_done   = word_take & (word_count == `SEG_CELL_WORDS - 4'h1);
	assign o_fetch_req = state == seg_context_pkg::ST_PAYLOAD;

	seg_crc_word u_crc
	(
		.i_crc  (current_crc),
		.i_data (i_fetch_data),
		.o_crc  (next_crc)
	);

	always_ff @(posedge i_mclk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			wr_pending <= 1'b0;
			wr_index   <= 6'h00;
		end
		else
		begin
			wr_pending <= bus_req & i_hwrite;
			if (bus_req)
				wr_index <= i_haddr[7:2];
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			o_hrdata <= `SEG_ZERO32;
		else if (bus_req & ~i_hwrite)
		begin
			unique case (i_haddr[7:2])
				`SEG_REG_CTRL:     o_hrdata <= {25'h000_0000, frame_active, address_events,
				                                segmentation_buffer_control, abr_mode, drop_select, conn_suspend};
				`SEG_REG_OFFSET:   o_hrdata <= 32'(buffer_offset);
				`SEG_REG_ENTRY:    o_hrdata <= {24'h00_0000, entry_point, 2'b00, event_modifier};
				`SEG_REG_HEADER:   o_hrdata <= cell_header_bytes;
				`SEG_REG_POINTER:  o_hrdata <= seg_pointer;
				`SEG_REG_CRC:      o_hrdata <= current_crc;
				`SEG_REG_BLOCK:    o_hrdata <= {packet_index, block_count, packets_per_frame, fixed_block_size};
				`SEG_REG_RATE:     o_hrdata <= {16'h0000, explicit_rate};
				`SEG_REG_IRQ_STAT: o_hrdata <= 32'(irq_status);
				`SEG_REG_IRQ_EN:   o_hrdata <= 32'(irq_enable);
				`SEG_REG_EVENT:    o_hrdata <= o_tx_event;
				default:           o_hrdata <= `SEG_ZERO32;
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			conn_suspend                <= 1'b0; // RULE_01
			drop_select                 <= 2'b00;
			abr_mode                    <= 1'b0;
			segmentation_buffer_control <= 1'b0;
			address_events              <= 1'b0;
			buffer_offset               <= '0;
			event_modifier              <= 2'b00;
			entry_point                 <= 4'h0;
			cell_header_bytes           <= `SEG_ZERO32;
			fixed_block_size            <= '0;
			packets_per_frame           <= '0;
			explicit_rate               <= 16'h0000;
			irq_enable                  <= '0;
		end
		else if (wr_now)
		begin
			if (reg_hit(wr_index, `SEG_REG_CTRL))
			begin
				conn_suspend                <= i_hwdata[`SEG_CTRL_SUSPEND];
				drop_select                 <= i_hwdata[`SEG_CTRL_DROP_HI:`SEG_CTRL_DROP_LO]; // RULE_02
				abr_mode                    <= i_hwdata[`SEG_CTRL_ABR];
				segmentation_buffer_control <= i_hwdata[`SEG_CTRL_MOD_EN];
				address_events              <= i_hwdata[`SEG_CTRL_ADDR_EVT];
			end
			if (reg_hit(wr_index, `SEG_REG_OFFSET))
				buffer_offset <= i_hwdata[OFS_W-1:0];
			if (reg_hit(wr_index, `SEG_REG_ENTRY))
			begin
				event_modifier <= i_hwdata[1:0];
				entry_point    <= i_hwdata[7:4];
			end
			if (reg_hit(wr_index, `SEG_REG_HEADER))
				cell_header_bytes <= i_hwdata;
			if (reg_hit(wr_index, `SEG_REG_BLOCK))
			begin
				fixed_block_size  <= i_hwdata[CNT_W-1:0];
				packets_per_frame <= i_hwdata[2*CNT_W-1:CNT_W];
			end
			if (reg_hit(wr_index, `SEG_REG_RATE))
				explicit_rate <= i_hwdata[15:0]; // RULE_16
			if (reg_hit(wr_index, `SEG_REG_IRQ_EN))
				irq_enable <= i_hwdata[`SEG_IRQ_BITS-1:0];
		end
	end

	// buffer base is written by software; the pointer register shows the live pointer
	always_ff @(posedge i_mclk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			buffer_base <= `SEG_ZERO32;
		else if (wr_now & reg_hit(wr_index, `SEG_REG_POINTER) & ~frame_active)
			buffer_base <= i_hwdata;
	end

	always_ff @(posedge i_mclk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			state      <= seg_context_pkg::ST_IDLE;
			word_count <= 4'h0;
		end
		else
		begin
			unique case (state)
				seg_context_pkg::ST_IDLE:
				begin
					word_count <= 4'h0;
					if (i_cell_opportunity & frame_active & ~(abr_mode & conn_suspend)) // RULE_01
						state <= seg_context_pkg::ST_HEADER;
				end
				seg_context_pkg::ST_HEADER:
					state <= seg_context_pkg::ST_PAYLOAD;
				seg_context_pkg::ST_PAYLOAD:
				begin
					if (word_take)
						word_count <= word_count + 4'h1;
					if (cell_done)
						state <= (frame_end | (block_hit & packet_hit)) ? seg_context_pkg::ST_TRAILER
						                                                 : seg_context_pkg::ST_IDLE;
				end
				seg_context_pkg::ST_TRAILER:
					state <= seg_context_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			seg_pointer  <= `SEG_ZERO32;
			current_crc  <= `SEG_CRC_INIT;
			block_count  <= '0;
			packet_index <= '0;
			frame_active <= 1'b0;
			frame_end    <= 1'b0;
		end
		else if (start_req)
		begin
			seg_pointer  <= buffer_base + 32'(buffer_offset); // RULE_03 RULE_09
			current_crc  <= `SEG_CRC_INIT;
			block_count  <= '0; // RULE_15
			packet_index <= '0;
			frame_active <= 1'b1;
			frame_end    <= 1'b0;
		end
		else if (word_take)
		begin
			seg_pointer <= seg_pointer + `SEG_WORD_BYTES;
			current_crc <= next_crc; // RULE_10
			if (block_hit)
			begin
				block_count <= '0; // RULE_17
				if (packet_hit)
				begin
					packet_index <= '0; // RULE_18
					frame_end    <= 1'b1; // RULE_14
				end
				else
					packet_index <= packet_index + CNT_W'(1); // RULE_13
			end
			else
				block_count <= block_count + CNT_W'(1); // RULE_11
		end
		else if (state == seg_context_pkg::ST_TRAILER)
		begin
			current_crc  <= `SEG_CRC_INIT;
			frame_active <= 1'b0;
			frame_end    <= 1'b0;
		end
	end

	// cell side outputs, all registered
	always_ff @(posedge i_mclk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_cell_start  <= 1'b0;
			o_cell_header <= `SEG_ZERO32;
			o_update_ip   <= 4'h0;
			o_cellgen_ip  <= 4'h0;
			o_drop        <= 4'h0;
			o_word_valid  <= 1'b0;
			o_word_data   <= `SEG_ZERO32;
			o_word_last   <= 1'b0;
		end
		else
		begin
			o_cell_start <= state == seg_context_pkg::ST_HEADER;
			o_word_valid <= word_take | (state == seg_context_pkg::ST_TRAILER);
			o_word_last  <= state == seg_context_pkg::ST_TRAILER;
			if (state == seg_context_pkg::ST_HEADER)
			begin
				o_cell_header <= cell_header_bytes; // RULE_08
				o_update_ip   <= entry_point; // RULE_06 RULE_07
				o_cellgen_ip  <= entry_point; // RULE_06
				o_drop        <= 4'h1 << drop_select; // RULE_02
			end
			if (word_take)
				o_word_data <= i_fetch_data;
			else if (state == seg_context_pkg::ST_TRAILER)
				o_word_data <= ~current_crc;
		end
	end

	// o_fetch_addr is a flop copy-free view of the pointer
	assign o_fetch_addr = seg_pointer;

	always_ff @(posedge i_mclk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_tx_event_valid <= 1'b0;
			o_tx_event       <= `SEG_ZERO32;
		end
		else
		begin
			o_tx_event_valid <= state == seg_context_pkg::ST_TRAILER;
			if (state == seg_context_pkg::ST_TRAILER)
			begin
				if (!address_events)
					o_tx_event <= i_descriptor_addr; // RULE_05
				else if (segmentation_buffer_control)
					o_tx_event <= buffer_base
					            | {23'h00_0000, event_modifier, 7'h00}; // RULE_04
				else
					o_tx_event <= buffer_base;
			end
		end
	end

	always_comb
	begin
		irq_set                  = '0;
		irq_set[`SEG_IRQ_CELL]   = cell_done;
		irq_set[`SEG_IRQ_FRAME]  = state == seg_context_pkg::ST_TRAILER;
		irq_set[`SEG_IRQ_PACKET] = word_take & block_hit;
	end

	// a set in the clearing cycle wins, so no event is lost
	always_ff @(posedge i_mclk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			irq_status <= '0;
		else if (wr_now & reg_hit(wr_index, `SEG_REG_IRQ_CLR))
			irq_status <= (irq_status & ~i_hwdata[`SEG_IRQ_BITS-1:0]) | irq_set;
		else
			irq_status <= irq_status | irq_set;
	end

	always_ff @(posedge i_mclk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			o_irq <= 1'b0;
		else
			o_irq <= |(irq_status & irq_enable);
	end

endmodule
`default_nettype wire

/* verification/seg_context_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module seg_context_checker
(
	input wire logic        i_mclk,
	input wire logic        i_reset_n,
	input wire logic        i_fetch_valid,
	input wire logic [31:0] i_fetch_data,
	input wire logic        o_hreadyout,
	input wire logic        o_hresp,
	input wire logic        o_fetch_req,
	input wire logic [31:0] o_fetch_addr,
	input wire logic        o_cell_start,
	input wire logic [31:0] o_cell_header,
	input wire logic [3:0]  o_update_ip,
	input wire logic [3:0]  o_cellgen_ip,
	input wire logic [3:0]  o_drop,
	input wire logic        o_word_valid,
	input wire logic [31:0] o_word_data,
	input wire logic        o_word_last,
	input wire logic        o_tx_event_valid,
	input wire logic        o_irq
);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_reset_n);

	chk_bus_okay: assert property (o_hreadyout && !o_hresp)
		else $error("bus not ready or not okay");
	chk_drop_onehot: assert property (o_cell_start |-> $onehot(o_drop))
		else $error("drop select not one-hot");
	chk_ip_both: assert property (o_cell_start |-> o_update_ip == o_cellgen_ip)
		else $error("instruction pointers differ");
	chk_start_pulse: assert property (o_cell_start |=> !o_cell_start)
		else $error("cell start longer than one cycle");
	chk_cell_held: assert property (!o_cell_start |-> $stable(o_cell_header) && $stable(o_drop))
		else $error("header or drop changed outside cell start");
	chk_word_source: assert property (o_word_valid && !o_word_last |->
		$past(o_fetch_req && i_fetch_valid) && o_word_data == $past(i_fetch_data))
		else $error("payload word not from fetched data");
	chk_ptr_advance: assert property (o_fetch_req && i_fetch_valid |=>
		o_fetch_addr == $past(o_fetch_addr) + 32'h0000_0004)
		else $error("pointer did not advance by one word");
	chk_ptr_hold: assert property (o_fetch_req && !i_fetch_valid |=> $stable(o_fetch_addr))
		else $error("pointer moved without data");
	chk_last_event: assert property (o_word_last |-> o_tx_event_valid)
		else $error("frame end without transmit event");

	cover property (o_cell_start);
	cover property (o_word_last);
	cover property (o_fetch_req && !i_fetch_valid);
	cover property (o_irq);
endmodule

bind atm_segmentation_context seg_context_checker chk_u
(
	.i_mclk, .i_reset_n, .i_fetch_valid, .i_fetch_data, .o_hreadyout, .o_hresp, .o_fetch_req,
	.o_fetch_addr, .o_cell_start, .o_cell_header, .o_update_ip, .o_cellgen_ip, .o_drop,
	.o_word_valid, .o_word_data, .o_word_last, .o_tx_event_valid, .o_irq
);
`default_nettype wire

/* verification/seg_fetch_memory.sv */
`timescale 1ns/1ps
`default_nettype none
module seg_fetch_memory
(
	input  wire logic        i_mclk,
	input  wire logic        i_reset_n,
	input  wire logic        i_slow,
	input  wire logic        i_req,
	input  wire logic [31:0] i_addr,
	output logic             o_valid,
	output logic      [31:0] o_data
);
	logic        phase;
	logic [31:0] last;

	// slow mode answers every other cycle so the segmenter must stall
	always_ff @(posedge i_mclk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			phase <= 1'b0;
		else
			phase <= ~phase;
	end

	assign o_valid = i_req && (!i_slow || phase);
	// idle data is the inverse of the last word, so stale data never matches
	assign o_data = o_valid ? {i_addr[15:0], ~i_addr[15:0]} : ~last;

	always_ff @(posedge i_mclk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			last <= 32'h0000_0000;
		else if (o_valid)
			last <= o_data;
	end
endmodule
`default_nettype wire

/* verification/atm_segmentation_context_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "seg_context_defines.svh"
module atm_segmentation_context_tb;
	localparam logic [31:0] BASE = 32'h0000_1000;
	localparam logic [31:0] OFS  = 32'h0000_0010;
	localparam logic [31:0] DESC = 32'hCAFE_0040;
	logic        i_mclk, i_reset_n, i_hsel, i_hwrite, i_cell_opportunity, slow_mode;
	logic [31:0] i_haddr, i_hwdata, i_descriptor_addr, q;
	logic [1:0]  i_htrans;
	logic [2:0]  i_hsize;
	wire         i_hready, i_fetch_valid;
	wire  [31:0] i_fetch_data;
	logic        o_hreadyout, o_hresp, o_fetch_req, o_cell_start, o_word_valid, o_word_last;
	logic        o_tx_event_valid, o_irq;
	logic [31:0] o_hrdata, o_fetch_addr, o_cell_header, o_word_data, o_tx_event;
	logic [3:0]  o_update_ip, o_cellgen_ip, o_drop;
	int          errors, checks;

	assign i_hready = o_hreadyout;

	atm_segmentation_context dut_u
	(
		.i_mclk, .i_reset_n, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize, .i_hwdata, .i_hready,
		.o_hrdata, .o_hreadyout, .o_hresp, .i_cell_opportunity, .i_descriptor_addr, .o_fetch_req,
		.o_fetch_addr, .i_fetch_valid, .i_fetch_data, .o_cell_start, .o_cell_header, .o_update_ip,
		.o_cellgen_ip, .o_drop, .o_word_valid, .o_word_data, .o_word_last, .o_tx_event_valid,
		.o_tx_event, .o_irq
	);

	seg_fetch_memory mem_u
	(
		.i_mclk, .i_reset_n, .i_slow(slow_mode), .i_req(o_fetch_req), .i_addr(o_fetch_addr),
		.o_valid(i_fetch_valid), .o_data(i_fetch_data)
	);

	initial
	begin
		i_mclk = 1'b0;
		forever #4 i_mclk = ~i_mclk;
	end

	task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
		begin
			checks++;
			if (got !== exp)
			begin
				errors++;
				$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
			end
		end
	endtask

	task automatic report_and_stop();
		begin
			$display("errors %0d checks %0d", errors, checks);
			if (errors == 0 && checks > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask

	task automatic wait_ready();
		int n;
		begin
			for (n = 0; n < 20; n++)
			begin
				@(posedge i_mclk);
				if (o_hreadyout === 1'b1)
					return;
			end
			cmp("bus wait bound", 32'h0, 32'h1);
			report_and_stop();
		end
	endtask

	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		begin
			@(posedge i_mclk);
			i_hsel   <= 1'b1;
			i_htrans <= 2'b10;
			i_haddr  <= a;
			i_hwrite <= wr;
			wait_ready();
			i_hsel   <= 1'b0;
			i_htrans <= 2'b00;
			i_hwdata <= d;
			wait_ready();
			q = o_hrdata;
		end
	endtask

	task automatic rchk(input string name, input logic [31:0] a, input logic [31:0] exp);
		begin
			bus(1'b0, a, 32'h0000_0000);
			cmp(name, exp, q);
		end
	endtask

	function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] d);
		int i;
		begin
			for (i = 31; i >= 0; i--)
				c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? `SEG_CRC_POLY : 32'h0000_0000);
			return c;
		end
	endfunction

	// one cell that also closes the frame: 12 payload words then the trailer
	task automatic run_cell(input logic [3:0] drop, input logic [3:0] ip, input logic [31:0] evt);
		int          n;
		int          k;
		logic [31:0] crc;
		logic [31:0] a;
		begin
			@(posedge i_mclk);
			i_cell_opportunity <= 1'b1;
			n = 0;
			do
			begin
				@(negedge i_mclk);
				n++;
			end
			while (o_cell_start !== 1'b1 && n < 20);
			cmp("cell start", 32'h1, {31'h0, o_cell_start});
			// a cell that never starts would only run the payload walk out to its 200-cycle bound
			if (o_cell_start !== 1'b1)
				report_and_stop();
			cmp("header", 32'h1234_5678, o_cell_header);
			cmp("update ip", {28'h0, ip}, {28'h0, o_update_ip});
			cmp("cellgen ip", {28'h0, ip}, {28'h0, o_cellgen_ip});
			cmp("drop", {28'h0, drop}, {28'h0, o_drop});
			crc = `SEG_CRC_INIT;
			a = BASE + OFS;
			k = 0;
			for (n = 0; n < 200 && o_word_last !== 1'b1; n++)
			begin
				@(negedge i_mclk);
				if (o_word_valid === 1'b1 && o_word_last !== 1'b1)
				begin
					cmp("word", {a[15:0], ~a[15:0]}, o_word_data);
					crc = crc_step(crc, {a[15:0], ~a[15:0]});
					a = a + 32'h0000_0004;
					k++;
				end
			end
			cmp("word last", 32'h1, {31'h0, o_word_last});
			if (o_word_last !== 1'b1)
				report_and_stop();
			cmp("payload words", 32'h0000_000C, 32'(k));
			cmp("trailer", ~crc, o_word_data);
			cmp("event", evt, o_tx_event);
			@(posedge i_mclk);
			i_cell_opportunity <= 1'b0;
		end
	endtask

	initial
	begin
		int i;
		int n;
		errors = 0;
		checks = 0;
		i_reset_n = 1'b0;
		{i_hsel, i_hwrite, i_cell_opportunity, slow_mode} = 4'h0;
		{i_haddr, i_hwdata} = 64'h0;
		i_htrans = 2'b00;
		i_hsize = 3'b010;
		i_descriptor_addr = DESC;
		repeat (10) @(posedge i_mclk);
		i_reset_n <= 1'b1;
		rchk("ctrl reset", 32'h00, 32'h0000_0000);
		rchk("crc reset", 32'h14, 32'hFFFF_FFFF);
		bus(1'b1, 32'h3C, 32'h5A5A_5A5A);
		rchk("unmapped", 32'h3C, 32'h0000_0000);
		bus(1'b1, 32'h1C, 32'h0000_ABCD);
		rchk("rate", 32'h1C, 32'h0000_ABCD);
		for (i = 0; i < 16; i++)
		begin
			bus(1'b1, 32'h08, {24'h0, i[3:0], 4'h3});
			rchk("entry", 32'h08, {24'h0, i[3:0], 4'h3});
		end
		bus(1'b1, 32'h04, OFS);
		bus(1'b1, 32'h0C, 32'h1234_5678);
		bus(1'b1, 32'h18, 32'h0000_0206);
		bus(1'b1, 32'h28, 32'h0000_0007);
		bus(1'b1, 32'h08, 32'h0000_0013);
		bus(1'b1, 32'h10, BASE);
		bus(1'b1, 32'h00, 32'h0000_0052);
		run_cell(4'b0010, 4'h1, DESC);
		rchk("counters", 32'h18, 32'h0000_0206);
		rchk("pointer", 32'h10, BASE + OFS + 32'h0000_0030);
		rchk("ctrl idle", 32'h00, 32'h0000_0012);
		rchk("status", 32'h20, 32'h0000_0007);
		cmp("irq set", 32'h1, {31'h0, o_irq});
		bus(1'b1, 32'h24, 32'h0000_0007);
		rchk("status clear", 32'h20, 32'h0000_0000);
		cmp("irq clear", 32'h0, {31'h0, o_irq});
		bus(1'b1, 32'h28, 32'h0000_0000);
		bus(1'b1, 32'h08, 32'h0000_00F3);
		bus(1'b1, 32'h10, BASE);
		bus(1'b1, 32'h00, 32'h0000_007F);
		@(posedge i_mclk);
		slow_mode <= 1'b1;
		i_cell_opportunity <= 1'b1;
		n = 0;
		repeat (30)
		begin
			@(negedge i_mclk);
			n += int'(o_cell_start === 1'b1);
		end
		cmp("suspended starts", 32'h0, 32'(n));
		@(posedge i_mclk);
		i_cell_opportunity <= 1'b0;
		bus(1'b1, 32'h00, 32'h0000_003E);
		run_cell(4'b1000, 4'hF, BASE | 32'h0000_0180);
		// suspend without abr must not gate; modifier disabled leaves the base plain
		bus(1'b1, 32'h00, 32'h0000_0061);
		run_cell(4'b0001, 4'hF, BASE);
		rchk("event reg", 32'h2C, BASE);
		rchk("masked status", 32'h20, 32'h0000_0007);
		cmp("irq masked", 32'h0, {31'h0, o_irq});
		report_and_stop();
	end
endmodule
`default_nettype wire
